// ==== verilog/uart_flow_params.svh ====
// Offsets, field positions, reset values and timing counts for the UART flow block.
// Assumes a 20-bit APB byte address in which each register takes one aligned word.
`ifndef UART_FLOW_PARAMS_SVH
`define UART_FLOW_PARAMS_SVH

// Register indices; the byte address is four times the index.
`define IDX_DIV_LO 18'h0ffa7
`define IDX_DIV_HI 18'h0ffa8
`define IDX_RESUME 18'h0ffa9
`define IDX_PAUSE 18'h0ffaa
`define IDX_MASK 18'h0ffab
`define IDX_FLOW_CFG 18'h0ffb0
`define IDX_MODEM_CTL 18'h0ffb1
`define IDX_DMA_CTL 18'h0ffb2
`define IDX_STATUS 18'h0ffb3

// Reset values.
`define RST_DIV_LO 8'h08
`define RST_DIV_HI 8'h00
`define RST_CHAR 8'h00

// Interrupt mask fields.
`define MASK_MODEM 0
`define MASK_STATUS 1
`define MASK_TXRX 2
`define MASK_W 3

// Flow-control configuration fields.
`define FC_AUTO_CTS 0
`define FC_AUTO_RTS 1
`define FC_SW 2

// Modem-control fields.
`define MCR_RTS 1
`define MCR_SW 5

// DMA channel control fields.
`define DMA_EN 0
`define DMA_CONT 1

// Status fields.
`define ST_COUNT 0
`define ST_THROT 6
`define ST_PAUSED 7
`define ST_CTS 8
`define ST_HALF 9
`define ST_OVR 10

// Master clock 96 MHz over 6.5: alternate 6 and 7 cycles, 13 cycles per 2 ticks.
`define MASTER_MHZ 96
`define REF_DIV_X2 13
`define REF_SHORT (`REF_DIV_X2 / 2)
`define REF_LONG (`REF_DIV_X2 - `REF_SHORT)

// Receive FIFO depth and marks.
`define FIFO_DEPTH 32
`define MARK_HIGH 6'd28
`define MARK_LOW 6'd4

// Buffer memory layout.
`define BUF_BYTES 512
`define DBUF_BYTES 64
`define X_BASE 9'h000
`define Y_BASE 9'h020

`endif

// ==== verilog/uart_flow_pkg.sv ====
// Types for the UART divisor, flow-control and double-buffer block.
// Assumes the constants header is included by the files that use it.
package uart_flow_pkg;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } rx_char_type;

  typedef struct packed {
    logic [7:0] div_lo;
    logic [7:0] div_hi;
    logic [7:0] resume_char;
    logic [7:0] pause_char;
    logic [2:0] mask;
    logic [2:0] flow_cfg;
    logic [7:0] modem_control_reg;
    logic [1:0] dma_ctl;
    logic [2:0] ref_cnt;
    logic ref_long;
    logic ref_tick;
    logic [15:0] baud_cnt;
    logic os_tick;
    logic [31:0][7:0] mem;
    logic [4:0] wr_ptr;
    logic [4:0] rd_ptr;
    logic [5:0] count;
    logic out_valid;
    logic [7:0] out_data;
    logic throttled;
    logic overrun;
    logic rts_n;
    logic pend_pause;
    logic pend_resume;
    logic fc_valid;
    logic [7:0] fc_data;
    logic [2:0] cts_sync;
    logic cts_n;
    logic paused;
    logic tx_go;
    logic dma_half;
    logic dma_done;
    logic ubm_done;
    logic [8:0] dma_base;
    logic [8:0] ubm_base;
    logic irq_modem;
    logic irq_status;
    logic irq_txrx;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } state_type;

endpackage

// ==== verilog/uart_flow.sv ====
// Baud divisor, flow-control characters, receive FIFO with marks and buffer alternation.
// Assumes an APB master on pclk, a same-clock receiver and transmitter, and cts_n from a pin.
//
// What this block does
// - Divisor high byte register, resets zero.
// - Divisor low byte register, resets eight.
// - Reference clock is master over 6.5.
// - Tick at sixteen times baud rate.
// - Resume-character match interrupts when enabled.
// - Pause-character match halts transmit DMA, interrupts.
// - Flow characters sent are the registers.
// - Mask gates modem, status, transmit/receive interrupts.
// - 512-byte buffer with 64-byte double buffer.
// - DMA and buffer manager use opposite halves.
// - Continuous mode alternates halves without software.
// - 32-byte receive FIFO, marks 28 and 4.
// - Marks drive rts_n or send pause/resume.
// - Auto CTS, auto RTS, software flow independent.
// - Auto CTS suspends transmit DMA while high.
// - Software flow needs modem bit5 set, 7:6 clear.
// - Resume match restarts paused transmit DMA.
// - Swap once DMA and manager both report done, paused or not.
//
// The APB slave port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "uart_flow_params.svh"

module uart_flow (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [19:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire uart_flow_pkg::rx_char_type rx_char,
  output logic rx_out_valid,
  output logic [7:0] rx_out_data,
  input wire logic rx_out_ready,
  output logic fc_tx_valid,
  output logic [7:0] fc_tx_data,
  input wire logic fc_tx_ready,
  output logic os_tick,
  output logic rts_n,
  input wire logic cts_n_pin,
  output logic tx_dma_go,
  input wire logic dma_half_done,
  input wire logic ubm_half_done,
  output logic dma_buf_sel,
  output logic [8:0] dma_buf_base,
  output logic [8:0] ubm_buf_base,
  input wire logic modem_event,
  input wire logic status_event,
  input wire logic txrx_event,
  output logic irq_modem,
  output logic irq_status,
  output logic irq_txrx
);

  uart_flow_pkg::state_type s_q;
  uart_flow_pkg::state_type s_d;

  logic [17:0] idx;
  logic access;
  logic mapped;
  logic [15:0] divisor;
  logic sw_on;
  logic push;
  logic pop;
  logic resume_hit;
  logic pause_hit;
  logic [31:0] rd_word;
  logic [5:0] cnt_next;

  always_comb begin
    s_d = s_q;
    idx = paddr[19:2];
    access = psel && penable && !s_q.pready;
    divisor = {s_q.div_hi, s_q.div_lo};
    sw_on = s_q.flow_cfg[`FC_SW] && s_q.modem_control_reg[`MCR_SW] && (s_q.modem_control_reg[7:6] == 2'b00);
    push = 1'b0;
    pop = 1'b0;
    resume_hit = 1'b0;
    pause_hit = 1'b0;
    rd_word = 32'h0000_0000;
    mapped = 1'b1;
    cnt_next = s_q.count;

    // Registers answer one cycle into the access phase.
    case (idx)
      `IDX_DIV_LO: rd_word = {24'h00_0000, s_q.div_lo};
      `IDX_DIV_HI: rd_word = {24'h00_0000, s_q.div_hi};
      `IDX_RESUME: rd_word = {24'h00_0000, s_q.resume_char};
      `IDX_PAUSE: rd_word = {24'h00_0000, s_q.pause_char};
      `IDX_MASK: rd_word = {29'h0000_0000, s_q.mask};
      `IDX_FLOW_CFG: rd_word = {29'h0000_0000, s_q.flow_cfg};
      `IDX_MODEM_CTL: rd_word = {24'h00_0000, s_q.modem_control_reg};
      `IDX_DMA_CTL: rd_word = {30'h0000_0000, s_q.dma_ctl};
      `IDX_STATUS: begin
        rd_word[`ST_COUNT +: 6] = s_q.count;
        rd_word[`ST_THROT] = s_q.throttled;
        rd_word[`ST_PAUSED] = s_q.paused;
        rd_word[`ST_CTS] = s_q.cts_n;
        rd_word[`ST_HALF] = s_q.dma_half;
        rd_word[`ST_OVR] = s_q.overrun;
      end
      default: mapped = 1'b0;
    endcase
    if (paddr[1:0] != 2'b00) begin
      mapped = 1'b0;
    end

    s_d.pready = access;
    s_d.pslverr = access && !mapped;
    if (access) begin
      s_d.prdata = (mapped && !pwrite) ? rd_word : 32'h0000_0000;
    end

    // Baud reference: 6 and 7 master cycles alternately give division by 6.5.
    s_d.ref_tick = 1'b0;
    if (s_q.ref_cnt == (s_q.ref_long ? 3'(`REF_LONG - 1) : 3'(`REF_SHORT - 1))) begin
      s_d.ref_cnt = 3'h0;
      s_d.ref_long = !s_q.ref_long;
      s_d.ref_tick = 1'b1;
    end else begin
      s_d.ref_cnt = s_q.ref_cnt + 3'h1;
    end

    // A divisor of zero counts the full 65536 reference clocks.
    s_d.os_tick = 1'b0;
    if (s_q.ref_tick) begin
      if (s_q.baud_cnt == divisor - 16'h0001) begin
        s_d.baud_cnt = 16'h0000;
        s_d.os_tick = 1'b1;
      end else begin
        s_d.baud_cnt = s_q.baud_cnt + 16'h0001;
      end
    end

    // Register writes.
    if (access && pwrite && mapped) begin
      case (idx)
        `IDX_DIV_LO: begin
          s_d.div_lo = pwdata[7:0];
          s_d.baud_cnt = 16'h0000;
        end
        `IDX_DIV_HI: begin
          s_d.div_hi = pwdata[7:0];
          s_d.baud_cnt = 16'h0000;
        end
        `IDX_RESUME: s_d.resume_char = pwdata[7:0];
        `IDX_PAUSE: s_d.pause_char = pwdata[7:0];
        `IDX_MASK: s_d.mask = pwdata[`MASK_W-1:0];
        `IDX_FLOW_CFG: s_d.flow_cfg = pwdata[2:0];
        `IDX_MODEM_CTL: s_d.modem_control_reg = pwdata[7:0];
        `IDX_DMA_CTL: s_d.dma_ctl = pwdata[1:0];
        default: s_d.overrun = s_q.overrun && !pwdata[`ST_OVR];
      endcase
    end

    // Receive character compare; a pause match takes priority over resume.
    if (rx_char.valid) begin
      resume_hit = (rx_char.data == s_q.resume_char);
      pause_hit = (rx_char.data == s_q.pause_char);
      if (s_q.count == 6'(`FIFO_DEPTH)) begin
        s_d.overrun = 1'b1;
      end else begin
        push = 1'b1;
      end
    end

    // Output stage refills from the FIFO whenever it is empty or being taken.
    if (s_q.out_valid && rx_out_ready) begin
      s_d.out_valid = 1'b0;
    end
    if ((!s_q.out_valid || rx_out_ready) && s_q.count != 6'h00) begin
      pop = 1'b1;
      s_d.out_valid = 1'b1;
      s_d.out_data = s_q.mem[s_q.rd_ptr];
      s_d.rd_ptr = s_q.rd_ptr + 5'h01;
    end
    if (push) begin
      s_d.mem[s_q.wr_ptr] = rx_char.data;
      s_d.wr_ptr = s_q.wr_ptr + 5'h01;
    end
    cnt_next = s_q.count + {5'h00, push} - {5'h00, pop};
    s_d.count = cnt_next;

    // Hysteresis between the two fixed marks.
    if (!s_q.throttled && cnt_next >= `MARK_HIGH) begin
      s_d.throttled = 1'b1;
      if (sw_on) begin
        s_d.pend_pause = 1'b1;
        s_d.pend_resume = 1'b0;
      end
    end else if (s_q.throttled && cnt_next <= `MARK_LOW) begin
      s_d.throttled = 1'b0;
      if (sw_on) begin
        s_d.pend_resume = 1'b1;
        s_d.pend_pause = 1'b0;
      end
    end
    // The far sender is expected to stop while rts_n stays high.
    if (s_q.flow_cfg[`FC_AUTO_RTS]) begin
      s_d.rts_n = s_d.throttled;
    end else begin
      s_d.rts_n = !s_q.modem_control_reg[`MCR_RTS];
    end

    // Flow character offered to the transmitter, loaded from the live registers.
    if (s_q.fc_valid && fc_tx_ready) begin
      s_d.fc_valid = 1'b0;
    end
    if (!s_q.fc_valid || fc_tx_ready) begin
      if (s_d.pend_pause) begin
        s_d.fc_valid = 1'b1;
        s_d.fc_data = s_q.pause_char;
        s_d.pend_pause = 1'b0;
      end else if (s_d.pend_resume) begin
        s_d.fc_valid = 1'b1;
        s_d.fc_data = s_q.resume_char;
        s_d.pend_resume = 1'b0;
      end
    end

    // Clear-to-send pin: three stages, accepted once stages two and three agree.
    s_d.cts_sync = {s_q.cts_sync[1:0], cts_n_pin};
    if (s_q.cts_sync[1] == s_q.cts_sync[2]) begin
      s_d.cts_n = s_q.cts_sync[2];
    end

    // Transmit pause by received characters.
    if (!sw_on) begin
      s_d.paused = 1'b0;
    end else if (pause_hit) begin
      s_d.paused = 1'b1;
    end else if (resume_hit) begin
      s_d.paused = 1'b0;
    end
    s_d.tx_go = s_q.dma_ctl[`DMA_EN] && !s_d.paused
      && !(s_q.flow_cfg[`FC_AUTO_CTS] && s_d.cts_n);

    // Half alternation; a done pulse in the swap cycle belongs to the new half.
    s_d.dma_done = s_q.dma_done || dma_half_done;
    s_d.ubm_done = s_q.ubm_done || ubm_half_done;
    if (s_q.dma_ctl[`DMA_EN] && s_q.dma_ctl[`DMA_CONT] && s_q.dma_done && s_q.ubm_done) begin
      s_d.dma_half = !s_q.dma_half;
      s_d.dma_done = dma_half_done;
      s_d.ubm_done = ubm_half_done;
    end
    s_d.dma_base = s_d.dma_half ? `Y_BASE : `X_BASE;
    s_d.ubm_base = s_d.dma_half ? `X_BASE : `Y_BASE;

    // Interrupt gating only; the controller collects these outside.
    s_d.irq_modem = s_q.mask[`MASK_MODEM] && modem_event;
    s_d.irq_status = s_q.mask[`MASK_STATUS] && (status_event || resume_hit || pause_hit);
    s_d.irq_txrx = s_q.mask[`MASK_TXRX] && txrx_event;

    // A low clock enable freezes everything, bus answer included.
    if (!ce) begin
      s_d = s_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.div_lo <= `RST_DIV_LO;
      s_q.div_hi <= `RST_DIV_HI;
      s_q.resume_char <= `RST_CHAR;
      s_q.pause_char <= `RST_CHAR;
      s_q.ubm_base <= `Y_BASE;
      s_q.dma_base <= `X_BASE;
    end else begin
      s_q <= s_d;
    end
  end

  assign pready = s_q.pready;
  assign prdata = s_q.prdata;
  assign pslverr = s_q.pslverr;
  assign rx_out_valid = s_q.out_valid;
  assign rx_out_data = s_q.out_data;
  assign fc_tx_valid = s_q.fc_valid;
  assign fc_tx_data = s_q.fc_data;
  assign os_tick = s_q.os_tick;
  assign rts_n = s_q.rts_n;
  assign tx_dma_go = s_q.tx_go;
  assign dma_buf_sel = s_q.dma_half;
  assign dma_buf_base = s_q.dma_base;
  assign ubm_buf_base = s_q.ubm_base;
  assign irq_modem = s_q.irq_modem;
  assign irq_status = s_q.irq_status;
  assign irq_txrx = s_q.irq_txrx;

endmodule // uart_flow
`default_nettype wire

// ==== tb/uart_flow_asserts.sv ====
// Port checker for the UART flow block.
// Bound to every uart_flow instance; it watches only that instance's ports.
`timescale 1ns/100ps
`default_nettype none
`include "uart_flow_params.svh"
module uart_flow_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [19:0] paddr,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic rx_out_valid,
  input wire logic [7:0] rx_out_data,
  input wire logic rx_out_ready,
  input wire logic fc_tx_valid,
  input wire logic [7:0] fc_tx_data,
  input wire logic fc_tx_ready,
  input wire logic os_tick,
  input wire logic dma_buf_sel,
  input wire logic [8:0] dma_buf_base,
  input wire logic [8:0] ubm_buf_base,
  input wire logic modem_event,
  input wire logic txrx_event,
  input wire logic irq_modem,
  input wire logic irq_txrx
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  answer_wait_a: assert property (psel && penable && ce && !pready |=> pready || !ce)
    else $error("no answer one cycle after access");
  bad_addr_a: assert property ($rose(pready) && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access not refused");
  write_zero_a: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("read data not zero on write");
  modem_irq_a: assert property (irq_modem |-> $past(modem_event))
    else $error("modem interrupt without event");
  txrx_irq_a: assert property (irq_txrx |-> $past(txrx_event))
    else $error("txrx interrupt without event");
  tick_gap_a: assert property (os_tick |=> !os_tick [*5])
    else $error("oversampling ticks too close");
  buf_halves_a: assert property (dma_buf_base == (dma_buf_sel ? `Y_BASE : `X_BASE)
    && ubm_buf_base == (dma_buf_sel ? `X_BASE : `Y_BASE))
    else $error("halves not opposite");
  rx_hold_a: assert property (rx_out_valid && !rx_out_ready |=> rx_out_valid
    && $stable(rx_out_data))
    else $error("receive head dropped or changed");
  flow_hold_a: assert property (fc_tx_valid && !fc_tx_ready |=> fc_tx_valid
    && $stable(fc_tx_data))
    else $error("flow character dropped or changed");
  cover property (fc_tx_valid && fc_tx_ready);
  cover property ($changed(dma_buf_sel));
  cover property (irq_txrx);
endmodule // uart_flow_asserts
bind uart_flow uart_flow_asserts uart_flow_asserts_i (.*);
`default_nettype wire

// ==== tb/uart_flow_partner.sv ====
// Behavioural model of the external serial device on the far side.
// Assumes the bench loads bytes into q; slow stretches flow character intake.
`timescale 1ns/100ps
`default_nettype none
module uart_flow_partner (
  input wire logic pclk,
  input wire logic rts_n,
  input wire logic fc_tx_valid,
  input wire logic [7:0] fc_tx_data,
  input wire logic slow,
  output logic fc_tx_ready,
  output uart_flow_pkg::rx_char_type rx_char,
  output logic [7:0] last_fc
);
  logic [7:0] q[$];
  logic [1:0] wait_q;
  initial begin
    fc_tx_ready = 1'b0;
    rx_char = '0;
    last_fc = 8'h00;
    wait_q = 2'h0;
  end
  // An idle data bus keeps changing so stale bytes are never mistaken for data.
  always @(posedge pclk) begin
    if (!rts_n && q.size() > 0) begin
      rx_char <= {1'b1, q.pop_front()};
    end else begin
      rx_char <= {1'b0, ~rx_char.data};
    end
    if (fc_tx_valid && !fc_tx_ready) begin
      wait_q <= wait_q + 2'h1;
      if (!slow || wait_q == 2'h3) begin
        fc_tx_ready <= 1'b1;
        last_fc <= fc_tx_data;
      end else begin
        fc_tx_ready <= 1'b0;
      end
    end else begin
      fc_tx_ready <= 1'b0;
    end
  end
endmodule // uart_flow_partner
`default_nettype wire

// ==== tb/uart_flow_test.sv ====
// Self-checking bench for the UART flow block with its serial partner.
// Assumes design, package, header, checker and partner are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "uart_flow_params.svh"
module uart_flow_test;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, rx_out_valid;
  logic rx_out_ready, fc_tx_valid, fc_tx_ready, os_tick, rts_n, cts_n_pin, tx_dma_go;
  logic dma_half_done, ubm_half_done, dma_buf_sel, modem_event, status_event, txrx_event;
  logic irq_modem, irq_status, irq_txrx, slow, pause_seen, resume_seen;
  logic [19:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] rx_out_data, fc_tx_data, last_fc;
  logic [8:0] dma_buf_base, ubm_buf_base;
  uart_flow_pkg::rx_char_type rx_char;
  int n_fail, checks_done;
  assign pause_seen = last_fc == 8'h13;
  assign resume_seen = last_fc == 8'h11;
  uart_flow uart_flow_i (.*);
  uart_flow_partner uart_flow_partner_i (.pclk(pclk), .rts_n(rts_n), .slow(slow),
    .fc_tx_valid(fc_tx_valid), .fc_tx_data(fc_tx_data), .fc_tx_ready(fc_tx_ready),
    .rx_char(rx_char), .last_fc(last_fc));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("checks=%0d fails=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Every wait_for is bounded; running out ends the run as a failure.
  task automatic wait_for(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 3000) begin
      n_fail++;
      summarize();
    end
  endtask
  task automatic apb(input logic w, input logic [19:0] a, input logic [31:0] wd,
    output logic err);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    wait_for(pready, 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge keeps the next setup from overwriting this release.
    @(posedge pclk);
  endtask
  task automatic wr(input logic [17:0] i, input logic [31:0] d);
    logic e;
    apb(1'b1, {i, 2'b00}, d, e);
  endtask
  task automatic rdr(input logic [17:0] i);
    logic e;
    apb(1'b0, {i, 2'b00}, 32'h0, e);
  endtask
  task automatic t_regs;
    logic e;
    rdr(`IDX_DIV_LO);
    chk(rd, 32'h08);
    rdr(`IDX_DIV_HI);
    chk(rd, 32'h00);
    rdr(`IDX_RESUME);
    chk(rd, 32'h00);
    rdr(`IDX_MASK);
    chk(rd, 32'h00);
    wr(`IDX_MASK, 32'hff);
    rdr(`IDX_MASK);
    chk(rd, 32'h07);
    wr(`IDX_DIV_HI, 32'ha5);
    rdr(`IDX_DIV_HI);
    chk(rd, 32'ha5);
    wr(`IDX_DIV_HI, 32'h00);
    apb(1'b0, {18'h0ffa6, 2'b00}, 32'h0, e);
    chk(e, 1'b1);
    apb(1'b1, {`IDX_PAUSE, 2'b01}, 32'h5a, e);
    chk(e, 1'b1);
    rdr(`IDX_PAUSE);
    chk(rd, 32'h00);
  endtask
  task automatic t_baud(input logic [7:0] d);
    int n;
    wr(`IDX_DIV_LO, {24'h0, d});
    wait_for(os_tick, 1'b1);
    @(posedge pclk);
    n = 1;
    while (os_tick !== 1'b1 && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    chk(n, 13 * d / 2);
  endtask
  task automatic t_irq;
    for (int i = 0; i < 4; i++) begin
      wr(`IDX_MASK, 32'(i == 3 ? 0 : 1 << i));
      {modem_event, status_event, txrx_event} <= 3'h7;
      @(posedge pclk);
      {modem_event, status_event, txrx_event} <= 3'h0;
      @(posedge pclk);
      chk({irq_txrx, irq_status, irq_modem}, 32'(i == 3 ? 0 : 1 << i));
    end
  endtask
  task automatic t_flow;
    wr(`IDX_RESUME, 32'h11);
    wr(`IDX_PAUSE, 32'h13);
    wr(`IDX_MODEM_CTL, 32'h20);
    wr(`IDX_FLOW_CFG, 32'h6);
    slow <= 1'b1;
    wait_for(rts_n, 1'b0);
    for (int i = 0; i < 40; i++) uart_flow_partner_i.q.push_back(8'(8'h40 + i));
    wait_for(rts_n, 1'b1);
    wait_for(pause_seen, 1'b1);
    rdr(`IDX_STATUS);
    chk(rd[`ST_THROT], 1'b1);
    chk(32'(rd[5:0] >= 6'd28 && rd[5:0] <= 6'd32), 32'h1);
    chk(rx_out_data, 8'h40);
    chk(rx_out_valid, 1'b1);
    rx_out_ready <= 1'b1;
    wait_for(resume_seen, 1'b1);
    chk(rts_n, 1'b0);
  endtask
  task automatic t_gate;
    wr(`IDX_DMA_CTL, 32'h3);
    wr(`IDX_FLOW_CFG, 32'h7);
    wr(`IDX_MASK, 32'h2);
    cts_n_pin <= 1'b1;
    repeat (6) @(posedge pclk);
    chk(tx_dma_go, 1'b0);
    cts_n_pin <= 1'b0;
    repeat (6) @(posedge pclk);
    chk(tx_dma_go, 1'b1);
    uart_flow_partner_i.q.push_back(8'h13);
    wait_for(irq_status, 1'b1);
    wait_for(tx_dma_go, 1'b0);
    uart_flow_partner_i.q.push_back(8'h11);
    wait_for(irq_status, 1'b1);
    wait_for(tx_dma_go, 1'b1);
  endtask
  task automatic t_buf;
    chk({dma_buf_sel, dma_buf_base, ubm_buf_base}, {1'b0, `X_BASE, `Y_BASE});
    dma_half_done <= 1'b1;
    @(posedge pclk);
    dma_half_done <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(dma_buf_sel, 1'b0);
    ubm_half_done <= 1'b1;
    @(posedge pclk);
    ubm_half_done <= 1'b0;
    wait_for(dma_buf_sel, 1'b1);
    chk({dma_buf_base, ubm_buf_base}, {`Y_BASE, `X_BASE});
  endtask
  initial begin
    n_fail = 0;
    checks_done = 0;
    presetn = 1'b0;
    ce = 1'b1;
    cts_n_pin = 1'b0;
    paddr = 20'h0;
    pwdata = 32'h0;
    {psel, penable, pwrite, dma_half_done, ubm_half_done, slow, rx_out_ready} = '0;
    {modem_event, status_event, txrx_event} = 3'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_baud(8'd2);
    t_baud(8'd4);
    t_irq();
    t_flow();
    t_gate();
    t_buf();
    summarize();
  end
endmodule // uart_flow_test
`default_nettype wire
